// ---- scf_pkg.sv ----
// Purpose: Shared constants and types for the sinc3 decimating converter core
// Assumes: One clock domain, mclk at 250 MHz
// Notes: Input samples are 24-bit two's complement
package scf_pkg;
	// ==========================================
	// Clock division
	localparam int MCLK_HZ = 250000000;
	localparam logic [8:0] MOD_DIV_LAST = 9'h1ff;
	localparam logic [2:0] GAIN_LG_MAX = 3'h3;
	// ==========================================
	// Notch select (decimation ratio in modulator samples)
	localparam logic [11:0] NOTCH_RESET = 12'h146;
	localparam logic [11:0] NOTCH_MIN = 12'h013;
	localparam logic [11:0] NOTCH_MAX = 12'h7d0;
	// ==========================================
	// Datapath widths
	localparam int IN_W = 24;
	localparam int ACC_W = 28;
	localparam int INT_W = 34;
	localparam int OUT_W = 36;
	localparam logic signed [INT_W-1:0] DAC_LEVEL = 34'sh000800000;
	localparam logic [2:0] SETTLE_WORDS = 3'h4;
	typedef enum logic {SCF_SETTLING, SCF_SETTLED} scf_settle_e;
endpackage

// ---- scf_bit_if.sv ----
// Purpose: Carries the modulator bitstream to the decimator
// Assumes: valid is a one-cycle pulse per modulator sample
// Notes: bitOne high means the feedback DAC sat at plus full scale
`timescale 1ns/1ps
interface scf_bit_if;
	logic valid;
	logic bitOne;
	modport src (output valid, output bitOne);
	modport snk (input valid, input bitOne);
endinterface

// ---- scf_modulator.sv ----
// Purpose: Second-order one-bit sigma-delta loop modelled in the digital domain
// Assumes: tick marks one modulator cycle, sample holds the averaged input
// Notes: Integrators sized well past the 14% overrange so they never wrap
`timescale 1ns/1ps
module scf_modulator
	import scf_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic tick,
	input wire logic signed [IN_W-1:0] sample,
	scf_bit_if.src bitOut
);
	typedef struct packed {
		logic signed [INT_W-1:0] integ1;
		logic signed [INT_W-1:0] integ2;
		logic valid;
		logic bitOne;
	} scf_mod_s;
	scf_mod_s st_reg;
	scf_mod_s st_next;
	logic signed [INT_W-1:0] fb;
	logic signed [INT_W-1:0] i1;
	// ==========================================
	// Loop update
	always_comb
	begin
		st_next = st_reg;
		st_next.valid = 1'b0;
		fb = st_reg.bitOne ? DAC_LEVEL : -DAC_LEVEL;
		i1 = st_reg.integ1 + INT_W'(sample) - fb;
		if (tick)
		begin
			st_next.integ1 = i1;
			st_next.integ2 = st_reg.integ2 + i1 - fb;
			// Comparator decides next DAC level
			st_next.bitOne = (st_reg.integ2 + i1 - fb) >= 0;
			st_next.valid = 1'b1;
		end
	end
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	assign bitOut.valid = st_reg.valid;
	assign bitOut.bitOne = st_reg.bitOne;
endmodule

// ---- scf_sinc3.sv ----
// Purpose: Sinc-cubed decimator, ratio set by notch select
// Assumes: ratio already clamped to the legal range
// Notes: Modular arithmetic; wraps in integrators cancel in the combs
`timescale 1ns/1ps
module scf_sinc3
	import scf_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic restart,
	input wire logic [11:0] ratio,
	scf_bit_if.snk bitIn,
	output logic [OUT_W-1:0] word,
	output logic strobe
);
	typedef struct packed {
		logic [OUT_W-1:0] acc1;
		logic [OUT_W-1:0] acc2;
		logic [OUT_W-1:0] acc3;
		logic [OUT_W-1:0] d1;
		logic [OUT_W-1:0] d2;
		logic [OUT_W-1:0] d3;
		logic [11:0] cnt;
		logic [OUT_W-1:0] word;
		logic strobe;
	} scf_sinc_s;
	scf_sinc_s st_reg;
	scf_sinc_s st_next;
	logic [OUT_W-1:0] c1;
	logic [OUT_W-1:0] c2;
	// ==========================================
	// Integrate at modulator rate, comb at output rate
	always_comb
	begin
		st_next = st_reg;
		st_next.strobe = 1'b0;
		c1 = st_reg.acc3 - st_reg.d1;
		c2 = c1 - st_reg.d2;
		if (restart)
			st_next.cnt = '0;
		else if (bitIn.valid)
		begin
			st_next.acc1 = st_reg.acc1 + (bitIn.bitOne ? 36'h1 : 36'hfffffffff);
			st_next.acc2 = st_reg.acc2 + st_reg.acc1;
			st_next.acc3 = st_reg.acc3 + st_reg.acc2;
			if (st_reg.cnt >= ratio - 12'h1)
			begin
				st_next.cnt = '0;
				st_next.d1 = st_reg.acc3;
				st_next.d2 = c1;
				st_next.d3 = c2;
				st_next.word = c2 - st_reg.d3;
				st_next.strobe = 1'b1;
			end
			else
				st_next.cnt = st_reg.cnt + 12'h1;
		end
	end
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	assign word = st_reg.word;
	assign strobe = st_reg.strobe;
endmodule

// ---- scf_sinc3_top.sv ----
// Purpose: Decimating sinc3 converter core with modulator timing and settling
// Assumes: Inputs synchronous to mclk; analog input given as 24-bit samples
// Notes: Nominal input span +-0x700000; headroom reaches +-0x7fffff
`timescale 1ns/1ps
module scf_sinc3_top
	import scf_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic signed [IN_W-1:0] analogIn,
	input wire logic [2:0] gainSel,
	input wire logic [11:0] notchSelect,
	input wire logic notchLoad,
	input wire logic stepEvent,
	output logic [OUT_W-1:0] convData,
	output logic dataReady,
	output logic convValid,
	output logic modBit,
	output logic [11:0] notchActive
);
	typedef struct packed {
		logic [8:0] divCnt;
		logic signed [ACC_W-1:0] acc;
		logic signed [IN_W-1:0] avg;
		logic modTick;
		logic inTick;
		logic [11:0] notch;
		logic restart;
		logic [2:0] words;
		scf_settle_e settle;
		logic [OUT_W-1:0] data;
		logic ready;
		logic modBit;
	} scf_top_s;
	scf_top_s st_reg;
	scf_top_s st_next;
	logic [2:0] gainLg;
	logic [7:0] smpMask;
	logic signed [ACC_W-1:0] accSum;
	logic [11:0] notchClamp;
	logic [OUT_W-1:0] sincWord;
	logic sincStrobe;
	scf_bit_if bitLink();
	// ==========================================
	// Gain to sample spacing
	always_comb
	begin
		gainLg = (gainSel > GAIN_LG_MAX) ? GAIN_LG_MAX : gainSel;
		smpMask = 8'hff >> gainLg;
		accSum = st_reg.acc + ACC_W'(analogIn);
		if (notchSelect < NOTCH_MIN)
			notchClamp = NOTCH_MIN;
		else if (notchSelect > NOTCH_MAX)
			notchClamp = NOTCH_MAX;
		else
			notchClamp = notchSelect;
	end
	// ==========================================
	// Timing, notch, settling and output register
	always_comb
	begin
		st_next = st_reg;
		st_next.divCnt = st_reg.divCnt + 9'h1;
		st_next.modTick = (st_reg.divCnt == MOD_DIV_LAST);
		st_next.inTick = ((st_reg.divCnt[7:0] & smpMask) == smpMask);
		st_next.restart = 1'b0;
		st_next.ready = 1'b0;
		if (st_next.inTick)
		begin
			if (st_next.modTick)
			begin
				// Average of the gain-scaled multiple samples per cycle
				st_next.avg = IN_W'(accSum >>> (gainLg + 3'h1));
				st_next.acc = '0;
			end
			else
				st_next.acc = accSum;
		end
		if (notchLoad)
		begin
			st_next.notch = notchClamp;
			st_next.restart = 1'b1;
		end
		if (bitLink.valid)
			st_next.modBit = bitLink.bitOne;
		if (sincStrobe)
		begin
			st_next.data = sincWord;
			st_next.ready = 1'b1;
		end
		// Restart wins over a word finishing in the same cycle
		if (notchLoad || stepEvent)
		begin
			st_next.words = '0;
			st_next.settle = SCF_SETTLING;
		end
		else if (sincStrobe)
		begin
			case (st_reg.settle)
				SCF_SETTLING:
				begin
					st_next.words = st_reg.words + 3'h1;
					if (st_reg.words + 3'h1 == SETTLE_WORDS)
						st_next.settle = SCF_SETTLED;
				end
				SCF_SETTLED:
					st_next.words = st_reg.words;
				default:
					st_next.settle = SCF_SETTLING;
			endcase
		end
	end
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_reg <= '0;
			st_reg.notch <= NOTCH_RESET;
			st_reg.settle <= SCF_SETTLING;
		end
		else
			st_reg <= st_next;
	end
	// ==========================================
	// Datapath
	scf_modulator u_mod (
		.mclk(mclk),
		.resetn(resetn),
		.tick(st_reg.modTick),
		.sample(st_reg.avg),
		.bitOut(bitLink)
	);
	scf_sinc3 u_sinc (
		.mclk(mclk),
		.resetn(resetn),
		.restart(st_reg.restart),
		.ratio(st_reg.notch),
		.bitIn(bitLink),
		.word(sincWord),
		.strobe(sincStrobe)
	);
	// Channel switching is the host's duty; stepEvent restarts settling
	assign convData = st_reg.data;
	assign dataReady = st_reg.ready;
	assign convValid = (st_reg.settle == SCF_SETTLED);
	assign modBit = st_reg.modBit;
	assign notchActive = st_reg.notch;
	// ==========================================
	// Checks
	logic [9:0] tickGap;
	logic tickSeen;
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			tickGap <= '0;
			tickSeen <= 1'b0;
		end
		else if (st_reg.modTick)
		begin
			tickGap <= 10'h1;
			tickSeen <= 1'b1;
		end
		else
			tickGap <= tickGap + 10'h1;
	end
	sequence s_gainHigh32;
		st_reg.inTick && gainSel >= 3'h3 ##1 (gainSel >= 3'h3)[*8];
	endsequence
	sequence s_wordDone;
		sincStrobe && !notchLoad && !stepEvent;
	endsequence
	property p_modPeriod;
		@(posedge mclk) disable iff (!resetn)
		st_reg.modTick && tickSeen |-> tickGap == 10'h200;
	endproperty
	a_modPeriod: assert property (p_modPeriod) else $error("modulator tick spacing");
	property p_inRate8;
		@(posedge mclk) disable iff (!resetn)
		s_gainHigh32 |-> !st_reg.inTick ##1 (!st_reg.inTick)[*8];
	endproperty
	a_inRate8: assert property (p_inRate8) else $error("input sample spacing");
	property p_bitHold;
		@(posedge mclk) disable iff (!resetn)
		!bitLink.valid |=> $stable(st_reg.modBit);
	endproperty
	a_bitHold: assert property (p_bitHold) else $error("bit changed off tick");
	property p_wordLoad;
		@(posedge mclk) disable iff (!resetn)
		sincStrobe |=> dataReady && convData == $past(sincWord);
	endproperty
	a_wordLoad: assert property (p_wordLoad) else $error("output word not loaded");
	property p_restartInvalid;
		@(posedge mclk) disable iff (!resetn)
		(notchLoad || stepEvent) |=> !convValid;
	endproperty
	a_restartInvalid: assert property (p_restartInvalid) else $error("valid after step");
	property p_settleFour;
		@(posedge mclk) disable iff (!resetn)
		$rose(convValid) |-> $past(st_reg.words) == 3'h3 && $past(sincStrobe);
	endproperty
	a_settleFour: assert property (p_settleFour) else $error("settled early");
	property p_notchRange;
		@(posedge mclk) disable iff (!resetn)
		notchActive >= NOTCH_MIN && notchActive <= NOTCH_MAX;
	endproperty
	a_notchRange: assert property (p_notchRange) else $error("notch out of range");
	property p_notchLoad;
		@(posedge mclk) disable iff (!resetn)
		notchLoad |=> notchActive == $past(notchClamp) ##1 $stable(notchActive) || $past(notchLoad);
	endproperty
	a_notchLoad: assert property (p_notchLoad) else $error("notch not taken");
	property p_wordCount;
		@(posedge mclk) disable iff (!resetn)
		(s_wordDone and (st_reg.settle == SCF_SETTLING)) |=>
			st_reg.words == $past(st_reg.words) + 3'h1;
	endproperty
	a_wordCount: assert property (p_wordCount) else $error("settle count");
	// ==========================================
	// Word spacing tracker; a notch load breaks the spacing once
	logic [20:0] wordGap;
	logic wordArmed;
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			wordGap <= '0;
			wordArmed <= 1'b0;
		end
		else
		begin
			if (dataReady)
				wordGap <= 21'h1;
			else
				wordGap <= wordGap + 21'h1;
			if (notchLoad || st_reg.restart)
				wordArmed <= 1'b0;
			else if (dataReady)
				wordArmed <= 1'b1;
		end
	end
	property p_wordSpacing;
		@(posedge mclk) disable iff (!resetn)
		dataReady && wordArmed |-> wordGap == {st_reg.notch, 9'h000};
	endproperty
	a_wordSpacing: assert property (p_wordSpacing) else $error("word spacing off notch");
	property p_readySingle;
		@(posedge mclk) disable iff (!resetn)
		dataReady |=> !dataReady;
	endproperty
	a_readySingle: assert property (p_readySingle) else $error("ready longer than a cycle");
	property p_readyFromWord;
		@(posedge mclk) disable iff (!resetn)
		dataReady |-> $past(sincStrobe);
	endproperty
	a_readyFromWord: assert property (p_readyFromWord) else $error("ready without word");
	property p_dataHold;
		@(posedge mclk) disable iff (!resetn)
		!sincStrobe |=> $stable(convData);
	endproperty
	a_dataHold: assert property (p_dataHold) else $error("output changed between words");
	property p_validHold;
		@(posedge mclk) disable iff (!resetn)
		convValid && !notchLoad && !stepEvent |=> convValid;
	endproperty
	a_validHold: assert property (p_validHold) else $error("valid dropped without restart");
	property p_validWords;
		@(posedge mclk) disable iff (!resetn)
		convValid |-> st_reg.words == SETTLE_WORDS;
	endproperty
	a_validWords: assert property (p_validWords) else $error("valid before four words");
	property p_inTickGrid;
		@(posedge mclk) disable iff (!resetn)
		st_reg.inTick |-> ((st_reg.divCnt[7:0] - 8'h1) & $past(smpMask)) == $past(smpMask);
	endproperty
	a_inTickGrid: assert property (p_inTickGrid) else $error("input sample off grid");
	property p_modOnSample;
		@(posedge mclk) disable iff (!resetn)
		st_reg.modTick |-> st_reg.inTick;
	endproperty
	a_modOnSample: assert property (p_modOnSample) else $error("cycle end without sample");
	property p_bitFollows;
		@(posedge mclk) disable iff (!resetn)
		bitLink.valid |=> modBit == $past(bitLink.bitOne);
	endproperty
	a_bitFollows: assert property (p_bitFollows) else $error("bit output not taken");
	property p_strobeOnBit;
		@(posedge mclk) disable iff (!resetn)
		sincStrobe |-> $past(bitLink.valid);
	endproperty
	a_strobeOnBit: assert property (p_strobeOnBit) else $error("word without new bit");
endmodule

// ---- scf_far_side.sv ----
// Purpose: Far-side model: input source and output register reader
// Assumes: One clock; words are taken on dataReady
// Notes: Flags any convData change outside a dataReady cycle
`timescale 1ns/1ps
module scf_far_side
	import scf_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic signed [IN_W-1:0] level,
	input wire logic [OUT_W-1:0] convData,
	input wire logic dataReady,
	output logic signed [IN_W-1:0] analogIn,
	output logic [OUT_W-1:0] lastWord,
	output logic torn
);
	logic [OUT_W-1:0] seen;
	// Unarmed until out of reset, so the unknown start-up word is not flagged
	logic armed;
	// ==========================================
	// Source moves on the falling edge, clear of sampling
	initial
	begin
		analogIn = '0;
		seen = '0;
		armed = 1'b0;
		torn = 1'b0;
		lastWord = '0;
	end
	always @(negedge mclk)
		analogIn <= level;
	// ==========================================
	// Reader
	always @(posedge mclk)
	begin
		if (dataReady === 1'b1)
			lastWord <= convData;
		seen <= convData;
		armed <= resetn;
	end
	always @(negedge mclk)
		if (armed && dataReady !== 1'b1 && convData !== seen)
			torn <= 1'b1;
endmodule

// ---- sinc3_decimation_filter_bench.sv ----
// Purpose: Self-checking bench for the sinc3 converter core
// Assumes: mclk 250 MHz, inputs driven on the falling edge
// Notes: Shortest notch used so settling fits the run
`timescale 1ns/1ps
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin badCount++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module sinc3_decimation_filter_bench;
	import scf_pkg::*;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic signed [IN_W-1:0] level = '0;
	logic signed [IN_W-1:0] analogIn;
	logic [2:0] gainSel = 3'h0;
	logic [11:0] notchSelect = 12'h000;
	logic notchLoad = 1'b0;
	logic stepEvent = 1'b0;
	logic [OUT_W-1:0] convData;
	logic [OUT_W-1:0] lastWord;
	logic dataReady;
	logic convValid;
	logic modBit;
	logic torn;
	logic [11:0] notchActive;
	int badCount = 0;
	int cmpCount = 0;
	int onesCount;
	int allCount;
	always #2 mclk = ~mclk;
	scf_sinc3_top i_dut(.mclk(mclk), .resetn(resetn), .analogIn(analogIn),
		.gainSel(gainSel), .notchSelect(notchSelect), .notchLoad(notchLoad),
		.stepEvent(stepEvent), .convData(convData), .dataReady(dataReady),
		.convValid(convValid), .modBit(modBit), .notchActive(notchActive));
	scf_far_side i_far(.mclk(mclk), .resetn(resetn), .level(level), .convData(convData),
		.dataReady(dataReady), .analogIn(analogIn), .lastWord(lastWord), .torn(torn));
	// ==========================================
	// Shared tasks
	task automatic closeOut;
		$display("compares %0d mismatches %0d", cmpCount, badCount);
		if (badCount == 0 && cmpCount > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic waitWord(output int n);
		n = 0;
		do
		begin
			@(negedge mclk);
			n++;
			allCount++;
			if (modBit === 1'b1)
				onesCount++;
		end
		while (dataReady !== 1'b1 && n < 20000);
		if (n >= 20000)
		begin
			badCount++;
			closeOut();
		end
	endtask
	// ==========================================
	// Scenarios
	task automatic scenReset;
		`CHK(notchActive, NOTCH_RESET)
		`CHK(convValid, 1'b0)
	endtask
	task automatic scenNotch;
		logic [11:0] ins [4];
		logic [11:0] exps [4];
		ins = '{12'h005, 12'h7ff, 12'h100, 12'h013};
		exps = '{NOTCH_MIN, NOTCH_MAX, 12'h100, NOTCH_MIN};
		// Back-to-back loads, out-of-range ones clamped
		foreach (ins[i])
		begin
			notchSelect = ins[i];
			notchLoad = 1'b1;
			@(negedge mclk);
			`CHK(notchActive, exps[i])
			`CHK(convValid, 1'b0)
		end
		notchLoad = 1'b0;
	endtask
	task automatic scenSettle(input logic signed [IN_W-1:0] lv, input logic [2:0] g,
		input longint lo, input longint hi);
		int n;
		logic sgnOk;
		level = lv;
		gainSel = g;
		stepEvent = 1'b1;
		onesCount = 0;
		allCount = 0;
		@(negedge mclk);
		stepEvent = 1'b0;
		`CHK(convValid, 1'b0)
		// Data unused until four words have passed
		for (int k = 1; k <= 4; k++)
		begin
			waitWord(n);
			if (k > 1)
				`CHK(n, int'(NOTCH_MIN) * 512)
			`CHK(convValid, (k == 4))
		end
		sgnOk = $signed(convData) >= lo && $signed(convData) <= hi;
		`CHK(sgnOk, 1'b1)
		sgnOk = (lv > 0) ? (onesCount * 10 > allCount * 8) : (onesCount * 10 < allCount * 4);
		`CHK(sgnOk, 1'b1)
		// Reader takes the word at the edge that ends the ready cycle
		@(negedge mclk);
		`CHK(lastWord, convData)
		`CHK(torn, 1'b0)
	endtask
	// ==========================================
	// Main sequence
	initial
	begin
		longint full;
		full = longint'(NOTCH_MIN) ** 3;
		repeat (8) @(negedge mclk);
		resetn = 1'b1;
		@(negedge mclk);
		scenReset();
		scenNotch();
		// Negative first; overrange run then starts from small loop states
		scenSettle(-24'sh380000, 3'h7, -full / 2, -full / 3);
		// Overrange input past nominal span must not wrap
		scenSettle(24'sh7fffff, 3'h3, full * 7 / 8, full);
		closeOut();
	end
endmodule
